// [src/ddic_params.svh]
// Purpose: constants for the driver-disable and interrupt configuration block
// Assumes: 16-bit register words, one system clock
// Notes: bit positions of the configuration word
`ifndef DDIC_PARAMS_SVH
`define DDIC_PARAMS_SVH
`define DDIC_CFG_ADDR 9'h1c5
`define DDIC_STATUS_ADDR 9'h1d2
`define DDIC_CFG_RESET 16'h6000
`define DDIC_B_FWD_HOST 0
`define DDIC_B_FWD_C0C1 1
`define DDIC_B_FWD_C1C1 2
`define DDIC_B_FWD_C0C2 3
`define DDIC_B_FWD_C1C2 4
`define DDIC_B_RET_SEL 5
`define DDIC_B_PREDRV_UV_MASK 6
`define DDIC_B_FIVE_UV_MASK 7
`define DDIC_B_BOOST_UV_MASK 8
`define DDIC_B_ENPIN_MASK 9
`define DDIC_B_OVT_MASK 10
`define DDIC_B_BOOST_DIS 11
`define DDIC_B_BOOST_MON 12
`define DDIC_B_LAST_LS_OVR 13
`define DDIC_B_REG_SEL 14
`define DDIC_B_PART_OVR 15
`define DDIC_SYNC_STAGES 3
`endif

// [src/ddic_pkg.sv]
// Purpose: types for the driver-disable and interrupt configuration block
// Assumes: nothing beyond the params header
// Notes: core forward vector indexed by core number
package ddic_pkg;
    typedef logic [15:0] ddic_word_t;
    typedef logic [3:0] ddic_core_vec_t;
    typedef logic [2:0] ddic_sync_t;
endpackage

// [src/ddic_sync3.sv]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input asynchronous to clk
// Notes: stage one is read only by stage two
`timescale 1ns/1ps
`include "ddic_params.svh"
module ddic_sync3 #(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Async in, filtered out
    input wire logic asyncIn,
    output logic syncOut
);
    typedef struct packed {
        logic [2:0] stages;
        logic out;
    } ddic_sync_state_t;
    ddic_sync_state_t st_r;
    ddic_sync_state_t st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.stages = {st_r.stages[1:0], asyncIn};
        // Output takes stage three only when stages two and three agree
        if (st_r.stages[1] == st_r.stages[2]) begin
            st_nxt.out = st_r.stages[2];
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= {{3{INIT}}, INIT};
        end else begin
            st_r <= st_nxt;
        end
    end
    assign syncOut = st_r.out;
endmodule

// [src/ddic_top.sv]
// Purpose: driver-disable conditions, local interrupt and its forwarding, return request, driver options
// Assumes: register access via documented register port (address, write, read strobes)
// Notes: condition inputs are pins from analog monitors and pass synchronisers
// Contract
// R1: A 16-bit lockable read/write config register resets to 0x6000 (bits 14 and 13 set).
// R2: Bit 9 gates the driver-enable-pin disable condition into the local interrupt.
// R3: The overtemperature mask bit gates overtemperature into the local interrupt.
// R4: Bits 8, 7 and 6 gate boost, 5 V and pre-driver undervoltage into the local interrupt.
// R5: Bit 0 forwards the local interrupt to the host interrupt pin.
// R6: Bits 1 to 4 forward the local interrupt to each of the four microcores.
// R7: With return-select zero a return request goes to all cores when drivers re-enable.
// R8: With return-select one a return request goes to all cores when the status register is cleared.
// R9: Bit 11's disable bit makes boost undervoltage disable the drivers; the code clears driversOn (high sides, partial group); other low sides ignore it.
// R10: The boost monitor bit selects divide by 32 (zero) or by 4 (one).
// R11: Bit 13 enables low-side seven regardless of the enable pin.
// R12: Bit 15 keeps high-side five and low-side three and six free of the enable pin.
// R13: Bit 14 drives regulator select, zero internal, one external.
// R14: During bootstrap init the regulator select is the inverse of the latched debug strap.
// R15: The latched strap survives SPI reset and only power-on or pin reset update it.
// R16: Status error bits clear on a status write, or a status read when reset-on-read is set.
// R17: Local interrupt is the OR of masked conditions; each destination ANDs its forward bit.
`timescale 1ns/1ps
`include "ddic_params.svh"
module ddic_top
    import ddic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_reset,
    input wire logic power_on_reset_n,
    input wire logic pin_reset_n,
    // Register port
    input wire logic [8:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire ddic_word_t regWdata,
    input wire logic cfgLocked,
    input wire logic resetOnReadEn,
    output ddic_word_t regRdata,
    // Condition pins
    input wire logic driverEnablePin,
    input wire logic overTemp,
    input wire logic boostUv,
    input wire logic fiveVoltUv,
    input wire logic predrvUv,
    input wire logic debug_strap_pin,
    input wire logic bootstrapInit,
    // Outputs
    output logic host_interrupt_pin_n,
    output ddic_core_vec_t coreIrq,
    output logic coreReturnReq,
    output logic enHighSide,
    output logic enLowSide,
    output logic enLowSideSeven,
    output logic enPartialGroup,
    output logic boostDivBy4,
    output logic regSelExternal
);
    import ddic_pkg::*;

    typedef struct packed {
        ddic_word_t cfg;
        logic [6:0] status;
        logic strap;
        logic [1:0] porHist;
        logic [1:0] pinHist;
        logic driversOn;
        logic lsOn;
        logic retReq;
        logic hostIrq;
        ddic_core_vec_t coreIrqQ;
        ddic_word_t rdata;
    } ddic_state_t;

    ddic_state_t st_r;
    ddic_state_t st_nxt;
    logic drvEnS, ovtS, boostUvS, fiveUvS, predrvUvS;
    logic localIrq, drvAllowed, statusClear;

    function automatic logic cfgBit(input ddic_word_t c, input int idx);
        cfgBit = c[idx];
    endfunction

    // Enable pin idles high; a low reset value would fake a disable after reset
    ddic_sync3 #(.INIT(1'b1)) uSyncEn (.clk(clk), .sys_rst(sys_rst), .asyncIn(driverEnablePin), .syncOut(drvEnS));
    ddic_sync3 #(.INIT(1'b0)) uSyncOt (.clk(clk), .sys_rst(sys_rst), .asyncIn(overTemp), .syncOut(ovtS));
    ddic_sync3 #(.INIT(1'b0)) uSyncBu (.clk(clk), .sys_rst(sys_rst), .asyncIn(boostUv), .syncOut(boostUvS));
    ddic_sync3 #(.INIT(1'b0)) uSyncFu (.clk(clk), .sys_rst(sys_rst), .asyncIn(fiveVoltUv), .syncOut(fiveUvS));
    ddic_sync3 #(.INIT(1'b0)) uSyncPu (.clk(clk), .sys_rst(sys_rst), .asyncIn(predrvUv), .syncOut(predrvUvS));

    always_comb begin
        st_nxt = st_r;
        // Masked conditions ORed into local interrupt
        localIrq = (cfgBit(st_r.cfg, `DDIC_B_ENPIN_MASK) & ~drvEnS) // R2 R17
            | (cfgBit(st_r.cfg, `DDIC_B_OVT_MASK) & ovtS) // R3
            | (cfgBit(st_r.cfg, `DDIC_B_BOOST_UV_MASK) & boostUvS) // R4
            | (cfgBit(st_r.cfg, `DDIC_B_FIVE_UV_MASK) & fiveUvS) // R4
            | (cfgBit(st_r.cfg, `DDIC_B_PREDRV_UV_MASK) & predrvUvS); // R4
        drvAllowed = drvEnS & ~fiveUvS & ~predrvUvS
            & ~(cfgBit(st_r.cfg, `DDIC_B_BOOST_DIS) & boostUvS); // R9
        statusClear = (regAddr == `DDIC_STATUS_ADDR) & (regWrite | (regRead & resetOnReadEn)); // R16
        st_nxt.hostIrq = localIrq & cfgBit(st_r.cfg, `DDIC_B_FWD_HOST); // R5 R17
        st_nxt.coreIrqQ = {4{localIrq}} & st_r.cfg[`DDIC_B_FWD_C1C2:`DDIC_B_FWD_C0C1]; // R6 R17
        st_nxt.driversOn = drvAllowed;
        // Low sides ignore boost undervoltage
        st_nxt.lsOn = drvEnS & ~fiveUvS & ~predrvUvS;
        if (cfgBit(st_r.cfg, `DDIC_B_RET_SEL)) begin
            st_nxt.retReq = statusClear; // R8
        end else begin
            st_nxt.retReq = drvAllowed & ~st_r.driversOn; // R7
        end
        // Config write, honouring lock
        if (regWrite && regAddr == `DDIC_CFG_ADDR && !cfgLocked) begin
            st_nxt.cfg = regWdata; // R1
        end
        // Status: set wins over clear
        if (statusClear) begin
            st_nxt.status = 7'h00; // R16
        end
        st_nxt.status[0] = (statusClear ? 1'b0 : st_r.status[0]) | predrvUvS;
        st_nxt.status[1] = (statusClear ? 1'b0 : st_r.status[1]) | fiveUvS;
        st_nxt.status[2] = (statusClear ? 1'b0 : st_r.status[2])
            | (boostUvS & cfgBit(st_r.cfg, `DDIC_B_BOOST_DIS));
        st_nxt.status[3] = (statusClear ? 1'b0 : st_r.status[3]) | ovtS;
        st_nxt.status[4] = drvEnS;
        // Enable-pin latch: one while pin not low since clear
        st_nxt.status[5] = (statusClear ? 1'b1 : st_r.status[5]) & drvEnS;
        st_nxt.status[6] = 1'b0;
        // Strap captured at release of either hardware reset
        st_nxt.porHist = {st_r.porHist[0], power_on_reset_n};
        st_nxt.pinHist = {st_r.pinHist[0], pin_reset_n};
        if ((st_r.porHist == 2'b01) || (st_r.pinHist == 2'b01)) begin
            st_nxt.strap = debug_strap_pin; // R14 R15
        end
        if (regRead) begin
            case (regAddr)
                `DDIC_CFG_ADDR: st_nxt.rdata = st_r.cfg;
                `DDIC_STATUS_ADDR: st_nxt.rdata = {9'h000, st_r.status};
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || spi_reset) begin
            // Strap kept across SPI reset
            st_r <= '0;
            st_r.cfg <= `DDIC_CFG_RESET; // R1
            st_r.status <= 7'h20;
            // Strap and reset-pin history keep running so a release during reset is seen
            st_r.strap <= st_nxt.strap; // R15
            st_r.porHist <= st_nxt.porHist;
            st_r.pinHist <= st_nxt.pinHist;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdata = st_r.rdata;
    assign host_interrupt_pin_n = ~st_r.hostIrq; // R5
    assign coreIrq = st_r.coreIrqQ; // R6
    assign coreReturnReq = st_r.retReq; // R7 R8
    assign enHighSide = st_r.driversOn;
    assign enLowSide = st_r.lsOn;
    assign enLowSideSeven = st_r.lsOn | (cfgBit(st_r.cfg, `DDIC_B_LAST_LS_OVR) & ~fiveUvS & ~predrvUvS); // R11
    assign enPartialGroup = st_r.driversOn | (cfgBit(st_r.cfg, `DDIC_B_PART_OVR) & ~fiveUvS & ~predrvUvS); // R12
    assign boostDivBy4 = cfgBit(st_r.cfg, `DDIC_B_BOOST_MON); // R10
    // Bootstrap init bypasses the register bit
    assign regSelExternal = bootstrapInit ? ~st_r.strap : cfgBit(st_r.cfg, `DDIC_B_REG_SEL); // R13 R14
endmodule

// [tb/ddic_core_model.sv]
// Purpose: microcore side, counts return requests
// Assumes: one-cycle request pulses
// Notes: filtering of requests is left to microcode
`timescale 1ns/1ps
module ddic_core_model (
    // Clock, reset and request
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic returnReq,
    output int retCnt
);
    always_ff @(posedge clk) retCnt <= sys_rst ? 0 : retCnt + int'(returnReq);
endmodule

// [tb/ddic_properties.sv]
// Purpose: port checker for ddic_top
// Assumes: config word mirrored from register writes
// Notes: seven-cycle holds cover the condition synchronisers
`timescale 1ns/1ps
`include "ddic_params.svh"
module ddic_properties
    import ddic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_reset,
    // Register port and pins
    input wire logic [8:0] regAddr,
    input wire logic regWrite,
    input wire ddic_word_t regWdata,
    input wire logic cfgLocked,
    input wire logic overTemp,
    input wire logic bootstrapInit,
    // Outputs
    input wire logic host_interrupt_pin_n,
    input wire ddic_core_vec_t coreIrq,
    input wire logic coreReturnReq,
    input wire logic boostDivBy4,
    input wire logic regSelExternal
);
    ddic_word_t cfgM;
    always_ff @(posedge clk) begin
        if (sys_rst || spi_reset) cfgM <= `DDIC_CFG_RESET;
        else if (regWrite && regAddr == `DDIC_CFG_ADDR && !cfgLocked) cfgM <= regWdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst || spi_reset);
    sequence masksOff; cfgM[10:6] == 5'h0; endsequence
    sequence ovtHeld; overTemp && cfgM[`DDIC_B_OVT_MASK] && cfgM[`DDIC_B_FWD_HOST]; endsequence
    host_fwd_off_a: assert property (!cfgM[0] |=> host_interrupt_pin_n) else $error("host irq without forward");
    core_fwd_off_a: assert property (!sys_rst |=> (coreIrq & ~$past(cfgM[4:1])) == 4'h0) else $error("core irq");
    boost_div_a: assert property (boostDivBy4 == cfgM[`DDIC_B_BOOST_MON]) else $error("divider select");
    reg_sel_a: assert property (!bootstrapInit |-> regSelExternal == cfgM[14]) else $error("regulator select");
    all_masked_a: assert property (masksOff [*7] |=> host_interrupt_pin_n && coreIrq == 4'h0) else $error("masked irq");
    ovt_raise_a: assert property (ovtHeld [*7] |=> !host_interrupt_pin_n) else $error("overtemp irq missing");
    ret_clear_a: assert property (cfgM[5] && regWrite && regAddr == `DDIC_STATUS_ADDR |-> ##[1:2] coreReturnReq)
        else $error("return request missing");
    ret_pulse_a: assert property ($rose(coreReturnReq) |=> !coreReturnReq) else $error("return request too long");
endmodule
bind ddic_top ddic_properties chk (.clk, .sys_rst, .spi_reset, .regAddr, .regWrite, .regWdata, .cfgLocked,
    .overTemp, .bootstrapInit, .host_interrupt_pin_n, .coreIrq, .coreReturnReq, .boostDivBy4, .regSelExternal);

// [tb/ddic_tb_top.sv]
// Purpose: directed bench for ddic_top
// Assumes: inputs move 1 ns after the rising edge
// Notes: strap latched 1 at power-on release
`timescale 1ns/1ps
`include "ddic_params.svh"
module ddic_tb_top;
    import ddic_pkg::*;
    logic clk = 0, sys_rst = 1, spi_reset = 0, porN = 0, pinN = 1, regWrite = 0, regRead = 0, cfgLocked = 0;
    logic rorEn = 0, strap = 1, boot = 0, hostN, div4, regSel, ret;
    logic [8:0] regAddr = 9'h0;
    logic [4:0] fault = 5'h0;
    logic [3:0] en;
    ddic_word_t regWdata = 16'h0, rdata;
    ddic_core_vec_t coreIrq;
    int err_count = 0, checks_done = 0, cyc = 0, retCnt, n;
    always #4 clk = ~clk;
    ddic_top uut (.clk, .sys_rst, .spi_reset, .power_on_reset_n(porN), .pin_reset_n(pinN), .regAddr, .regWrite,
        .regRead, .regWdata, .cfgLocked, .resetOnReadEn(rorEn), .regRdata(rdata), .driverEnablePin(~fault[0]),
        .overTemp(fault[1]), .boostUv(fault[2]), .fiveVoltUv(fault[3]), .predrvUv(fault[4]),
        .debug_strap_pin(strap), .bootstrapInit(boot), .host_interrupt_pin_n(hostN), .coreIrq,
        .coreReturnReq(ret), .enHighSide(en[3]), .enLowSide(en[2]), .enLowSideSeven(en[1]), .enPartialGroup(en[0]),
        .boostDivBy4(div4), .regSelExternal(regSel));
    ddic_core_model cores (.clk, .sys_rst, .returnReq(ret), .retCnt);
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(input logic [8:0] a, input ddic_word_t d, input logic w);
        regAddr = a;
        regWdata = d;
        regWrite = w;
        regRead = !w;
        tick(1);
        regWrite = 0;
        regRead = 0;
        tick(1);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic t_regs();
        acc(`DDIC_CFG_ADDR, 16'h0, 0);
        chk("cfg reset", rdata, `DDIC_CFG_RESET);
        cfgLocked = 1;
        acc(`DDIC_CFG_ADDR, 16'h1000, 1);
        cfgLocked = 0;
        acc(`DDIC_CFG_ADDR, 16'h0, 0);
        chk("cfg locked", rdata, `DDIC_CFG_RESET);
        chk("regsel", 16'(regSel), 16'h1);
        acc(`DDIC_CFG_ADDR, 16'h1000, 1);
        chk("div sel", 16'({div4, regSel}), 16'h2);
        acc(9'h1ff, 16'h0, 0);
        chk("unmapped", rdata, 16'h0);
    endtask
    task automatic t_mask();
        int mb[5] = '{`DDIC_B_ENPIN_MASK, `DDIC_B_OVT_MASK, `DDIC_B_BOOST_UV_MASK, 7, 6};
        for (int i = 0; i < 5; i++) begin
            acc(`DDIC_CFG_ADDR, 16'h001f | (16'h1 << mb[(i + 1) % 5]), 1);
            fault = 5'h1 << i;
            tick(8);
            chk("irq masked", 16'({hostN, coreIrq}), 16'h10);
            acc(`DDIC_CFG_ADDR, 16'h001f | (16'h1 << mb[i]), 1);
            tick(2);
            chk("irq raised", 16'({hostN, coreIrq}), 16'h0f);
            fault = 5'h0;
            tick(8);
        end
    endtask
    task automatic t_fwd();
        logic [4:0] e;
        fault = 5'h2;
        for (int k = 0; k < 5; k++) begin
            e = 5'h1 << k;
            acc(`DDIC_CFG_ADDR, (16'h1 << `DDIC_B_OVT_MASK) | 16'(e), 1);
            tick(6);
            chk("forward", 16'({hostN, coreIrq}), 16'({~e[0], e[4:1]}));
        end
        fault = 5'h0;
        tick(8);
    endtask
    task automatic t_ret();
        n = retCnt;
        acc(`DDIC_CFG_ADDR, 16'h0020, 1);
        acc(`DDIC_STATUS_ADDR, 16'h0, 1);
        rorEn = 1;
        acc(`DDIC_STATUS_ADDR, 16'h0, 0);
        tick(2);
        chk("ret on clear", 16'(retCnt - n), 16'h2);
        acc(`DDIC_CFG_ADDR, 16'h0, 1);
        fault = 5'h1;
        tick(8);
        fault = 5'h0;
        tick(8);
        chk("ret on enable", 16'(retCnt - n), 16'h3);
    endtask
    task automatic t_drv();
        fault = 5'h4;
        acc(`DDIC_CFG_ADDR, 16'h0800, 1);
        tick(8);
        chk("boost disables hs", 16'(en), 16'h6);
        acc(`DDIC_STATUS_ADDR, 16'h0, 0);
        chk("status latch", rdata, 16'h0014);
        acc(`DDIC_CFG_ADDR, 16'h0000, 1);
        tick(2);
        chk("boost ignored", 16'(en), 16'hf);
        fault = 5'h1;
        acc(`DDIC_CFG_ADDR, 16'ha000, 1);
        tick(8);
        chk("overrides", 16'(en), 16'h3);
        fault = 5'h0;
        tick(8);
    endtask
    task automatic t_strap();
        boot = 1;
        strap = 0;
        spi_reset = 1;
        tick(1);
        spi_reset = 0;
        tick(4);
        chk("strap kept", 16'(regSel), 16'h0);
        pinN = 0;
        tick(2);
        pinN = 1;
        tick(4);
        chk("strap new", 16'(regSel), 16'h1);
    endtask
    // Hang guard well above the roughly 260-cycle sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        tick(10);
        porN = 1;
        tick(10);
        sys_rst = 0;
        t_regs();
        t_mask();
        t_fwd();
        t_ret();
        t_drv();
        t_strap();
        end_sim();
    end
endmodule
